// ==== design/arvc_rate_src.sv ====
// Rate and voltage-source configuration registers with conversion sequencing.
// Assumes the serial command decoder presents one-cycle write and read strobes; read data is registered, one cycle after the strobe.
// ==========================================
// Summary of operation
// - Swap-average bit set swaps inputs and averages two readings; clear, none.
// - Bit 6 picks internal oscillator (0, default) or external clock (1).
// - Bit 5 picks continuous (0, default) or single-shot (1) conversion.
// - Bit 4 picks sinc3 (0) or low-latency filter (1, default).
// - Four-bit rate code sets data rate; default 0100; top code reserved.
// - Rate register at 04h, reads 14h after reset.
// - Monitor field: off, low, low and upper, low plus pull-together.
// - Bit 5 bypasses positive buffer; default enabled.
// - Bit 4 bypasses negative buffer; default bypassed.
// - Source select: pair one, pair two, internal source, reserved.
// - Internal source: off, on with power-down, always on, reserved.
// - Source register at 05h, reads 10h after reset.
// - Changing write resets filter and restarts conversion after start delay.
`timescale 1ns/1ps
`include "arvc_params.svh"
module arvc_rate_src (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ext_clk,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic start_req,
  input wire logic power_down,
  output logic swap_average,
  output logic swap_phase,
  output logic ext_clk_select,
  output logic single_shot,
  output logic low_latency,
  output logic [3:0] rate_code,
  output arvc_pkg::arvc_mon_t source_monitor_enable,
  output logic source_low_monitor,
  output logic source_upper_monitor,
  output logic source_pull_together,
  output logic positive_buffer_bypass,
  output logic negative_buffer_bypass,
  output arvc_pkg::arvc_sel_t source_select,
  output logic internal_source_on,
  output logic filter_reset,
  output logic converting,
  output logic mod_tick
);
  logic [7:0] rate_reg;
  logic [7:0] rate_next;
  logic [7:0] src_reg;
  logic [7:0] src_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic frst_reg;
  logic frst_next;
  logic phase_reg;
  logic phase_next;
  logic [3:0] dly_reg;
  logic [3:0] dly_next;
  arvc_pkg::arvc_conv_t st_reg;
  arvc_pkg::arvc_conv_t st_next;
  logic changed;
  logic tick;
  arvc_pkg::arvc_isrc_t isrc;
  // ==========================================
  // Modulator timing
  arvc_mod_tick u_tick (
    .ref_clk(ref_clk),
    .srst(srst),
    .use_ext(rate_reg[`ARVC_CLKSEL_BIT]),
    .ext_clk(ext_clk),
    .tick(tick)
  );
  assign mod_tick = tick;
  // ==========================================
  // Register file
  always_comb begin
    rate_next = rate_reg;
    src_next = src_reg;
    rdata_next = rdata_reg;
    rvalid_next = rd_en;
    changed = 1'b0;
    if (wr_en && addr == `ARVC_RATE_ADDR) begin
      rate_next = wr_data;
      changed = (wr_data != rate_reg);
    end
    if (wr_en && addr == `ARVC_SRC_ADDR) begin
      src_next = wr_data;
      changed = (wr_data != src_reg);
    end
    if (rd_en) begin
      unique case (addr)
        `ARVC_RATE_ADDR: rdata_next = rate_reg;
        `ARVC_SRC_ADDR: rdata_next = src_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rate_reg <= `ARVC_RATE_RESET;
      src_reg <= `ARVC_SRC_RESET;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rate_reg <= rate_next;
      src_reg <= src_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end
  assign rd_data = rdata_reg;
  assign rd_valid = rvalid_reg;
  // ==========================================
  // Field decode
  assign swap_average = rate_reg[`ARVC_SWAP_BIT];
  assign ext_clk_select = rate_reg[`ARVC_CLKSEL_BIT];
  assign single_shot = rate_reg[`ARVC_MODE_BIT];
  assign low_latency = rate_reg[`ARVC_FILTER_BIT];
  assign rate_code = rate_reg[`ARVC_RATE_LSB +: 4];
  assign source_monitor_enable = arvc_pkg::arvc_mon_t'(src_reg[`ARVC_MON_LSB +: 2]);
  assign source_low_monitor = (source_monitor_enable != arvc_pkg::ARVC_MON_OFF);
  assign source_upper_monitor = (source_monitor_enable == arvc_pkg::ARVC_MON_BOTH);
  assign source_pull_together = (source_monitor_enable == arvc_pkg::ARVC_MON_PULL);
  assign positive_buffer_bypass = src_reg[`ARVC_PBYP_BIT];
  assign negative_buffer_bypass = src_reg[`ARVC_NBYP_BIT];
  assign source_select = arvc_pkg::arvc_sel_t'(src_reg[`ARVC_SEL_LSB +: 2]);
  assign isrc = arvc_pkg::arvc_isrc_t'(src_reg[`ARVC_ISRC_LSB +: 2]);
  // Reserved code leaves the source off, a safe reading of an undefined setting
  always_comb begin
    unique case (isrc)
      arvc_pkg::ARVC_ISRC_OFF: internal_source_on = 1'b0;
      arvc_pkg::ARVC_ISRC_ON_PD: internal_source_on = ~power_down;
      arvc_pkg::ARVC_ISRC_ALWAYS: internal_source_on = 1'b1;
      arvc_pkg::ARVC_ISRC_RSVD: internal_source_on = 1'b0;
    endcase
  end
  // ==========================================
  // Conversion sequencing
  always_comb begin
    st_next = st_reg;
    dly_next = dly_reg;
    frst_next = 1'b0;
    phase_next = phase_reg;
    if (changed || start_req) begin
      st_next = arvc_pkg::ARVC_DELAY;
      dly_next = 4'h0;
      frst_next = changed;
      phase_next = 1'b0;
    end else begin
      unique case (st_reg)
        arvc_pkg::ARVC_IDLE: st_next = arvc_pkg::ARVC_IDLE;
        arvc_pkg::ARVC_DELAY: begin
          if (tick) begin
            if (dly_reg == 4'(`ARVC_START_DELAY_MOD - 1)) begin
              st_next = arvc_pkg::ARVC_RUN;
            end else begin
              dly_next = dly_reg + 4'h1;
            end
          end
        end
        arvc_pkg::ARVC_RUN: begin
          if (tick && swap_average) begin
            phase_next = ~phase_reg;
          end
          if (power_down) begin
            st_next = arvc_pkg::ARVC_IDLE;
          end
        end
      endcase
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_reg <= arvc_pkg::ARVC_DELAY;
      dly_reg <= 4'h0;
      frst_reg <= 1'b0;
      phase_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      dly_reg <= dly_next;
      frst_reg <= frst_next;
      phase_reg <= phase_next;
    end
  end
  assign filter_reset = frst_reg;
  assign converting = (st_reg == arvc_pkg::ARVC_RUN);
  assign swap_phase = phase_reg & swap_average;
  // ==========================================
  // Checks
  // Reset value checked one edge after the reset edge, so no history before time zero is used
  a_rate_reset: assert property (@(posedge ref_clk) srst |=> rate_reg == `ARVC_RATE_RESET)
    else $error("rate register not at reset value");
  a_src_reset: assert property (@(posedge ref_clk) srst |=> src_reg == `ARVC_SRC_RESET)
    else $error("source register not at reset value");
  a_write_rate: assert property (@(posedge ref_clk) disable iff (srst)
    wr_en && addr == 8'h04 |=> rate_reg == $past(wr_data))
    else $error("rate write not stored");
  a_write_src: assert property (@(posedge ref_clk) disable iff (srst)
    wr_en && addr == 8'h05 |=> src_reg == $past(wr_data))
    else $error("source write not stored");
  a_change_reset: assert property (@(posedge ref_clk) disable iff (srst)
    changed |=> filter_reset && !converting)
    else $error("change did not reset filter");
  a_no_swap: assert property (@(posedge ref_clk) disable iff (srst)
    !swap_average |-> !swap_phase)
    else $error("swap without enable");
  a_isrc_always: assert property (@(posedge ref_clk) disable iff (srst)
    isrc == arvc_pkg::ARVC_ISRC_ALWAYS |-> internal_source_on)
    else $error("always-on source is off");
  a_isrc_pd: assert property (@(posedge ref_clk) disable iff (srst)
    isrc == arvc_pkg::ARVC_ISRC_ON_PD && power_down |-> !internal_source_on)
    else $error("source on during power-down");
  a_upper_mon: assert property (@(posedge ref_clk) disable iff (srst)
    source_upper_monitor |-> source_low_monitor && src_reg[7:6] == 2'h2)
    else $error("upper monitor without low monitor");
  a_buf_fields: assert property (@(posedge ref_clk) disable iff (srst)
    positive_buffer_bypass == src_reg[5] && negative_buffer_bypass == src_reg[4])
    else $error("buffer bypass mismatch");
  c_rate_write: cover property (@(posedge ref_clk) wr_en && addr == 8'h04 && changed);
  c_run: cover property (@(posedge ref_clk) $rose(converting));
  c_swap: cover property (@(posedge ref_clk) converting && $changed(swap_phase));
endmodule : arvc_rate_src

// ==== shared/arvc_params.svh ====
// Register offsets, field positions, reset values and timing counts of the rate/source block.
// Assumes inclusion by bare name from design files.
`ifndef ARVC_PARAMS_SVH
`define ARVC_PARAMS_SVH
// ==========================================
// Register map
`define ARVC_RATE_ADDR 8'h04
`define ARVC_SRC_ADDR 8'h05
`define ARVC_RATE_RESET 8'h14
`define ARVC_SRC_RESET 8'h10
// ==========================================
// Rate register fields
`define ARVC_SWAP_BIT 7
`define ARVC_CLKSEL_BIT 6
`define ARVC_MODE_BIT 5
`define ARVC_FILTER_BIT 4
`define ARVC_RATE_LSB 0
`define ARVC_RATE_RESERVED 4'hF
// ==========================================
// Source register fields
`define ARVC_MON_LSB 6
`define ARVC_PBYP_BIT 5
`define ARVC_NBYP_BIT 4
`define ARVC_SEL_LSB 2
`define ARVC_ISRC_LSB 0
// ==========================================
// Timing
`define ARVC_INT_OSC_HZ 4096000
`define ARVC_CLK_HZ 100000000
`define ARVC_OSC_HALF_CYC ((`ARVC_CLK_HZ + `ARVC_INT_OSC_HZ * 2 - 1) / (`ARVC_INT_OSC_HZ * 2))
`define ARVC_START_DELAY_MOD 14
`endif

// ==== shared/arvc_pkg.sv ====
// Types of the rate/source configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
package arvc_pkg;
  typedef enum logic [1:0] {ARVC_MON_OFF, ARVC_MON_LOW, ARVC_MON_BOTH, ARVC_MON_PULL} arvc_mon_t;
  typedef enum logic [1:0] {ARVC_SEL_PAIR0, ARVC_SEL_PAIR1, ARVC_SEL_INT, ARVC_SEL_RSVD} arvc_sel_t;
  typedef enum logic [1:0] {ARVC_ISRC_OFF, ARVC_ISRC_ON_PD, ARVC_ISRC_ALWAYS, ARVC_ISRC_RSVD}
    arvc_isrc_t;
  typedef enum logic [1:0] {ARVC_IDLE, ARVC_DELAY, ARVC_RUN} arvc_conv_t;
endpackage : arvc_pkg

// ==== design/arvc_mod_tick.sv ====
// Modulator tick generator: derives the modulator rate from the internal oscillator or an
// external clock pin. Assumes ext_clk is asynchronous and is synchronised here.
`timescale 1ns/1ps
`include "arvc_params.svh"
module arvc_mod_tick (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic use_ext,
  input wire logic ext_clk,
  output logic tick
);
  logic [1:0] sync_reg;
  logic [1:0] sync_next;
  logic ext_last_reg;
  logic ext_last_next;
  logic [7:0] div_reg;
  logic [7:0] div_next;
  logic osc_reg;
  logic osc_next;
  logic osc_rise;
  // ==========================================
  // Divider and synchroniser
  always_comb begin
    sync_next = {sync_reg[0], ext_clk};
    ext_last_next = sync_reg[1];
    osc_rise = 1'b0;
    osc_next = osc_reg;
    div_next = div_reg + 8'h01;
    if (div_reg == 8'((`ARVC_OSC_HALF_CYC) - 1)) begin
      div_next = 8'h00;
      osc_next = ~osc_reg;
      osc_rise = ~osc_reg;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync_reg <= 2'h0;
      ext_last_reg <= 1'b0;
      div_reg <= 8'h00;
      osc_reg <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      ext_last_reg <= ext_last_next;
      div_reg <= div_next;
      osc_reg <= osc_next;
    end
  end
  // External edge seen only after two flops
  assign tick = use_ext ? (sync_reg[1] & ~ext_last_reg) : osc_rise;
endmodule : arvc_mod_tick

// ==== verif/arvc_host_model.sv ====
// Host controller model: issues register writes and reads as one-cycle strobes.
// Assumes the block takes a strobe on the rising edge of ref_clk.
`timescale 1ns/1ps
module arvc_host_model (
  input wire logic ref_clk,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
  end
  // ==========================================
  // Access tasks
  // Released lines show the inverse, so a stale value is never mistaken for a live one
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wr_data <= ~d;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    addr <= ~a;
    // Answer stands for one cycle after the strobe is taken; sample it settled
    #1;
    ok = rd_valid;
    d = rd_data;
    @(posedge ref_clk);
  endtask : read_reg
endmodule : arvc_host_model

// ==== verif/adc_rate_and_vref_config_test.sv ====
// Bench for the rate and source registers: reset values, fields, restarts.
// Assumes the host model drives the strobes; ext_clk runs unrelated in phase.
`timescale 1ns/1ps
module adc_rate_and_vref_config_test;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic ext_clk = 1'b0;
  logic start_req = 1'b0;
  logic power_down = 1'b0;
  logic wr_en, rd_en, rd_valid, swap_average, swap_phase, ext_clk_select, single_shot;
  logic low_latency, source_low_monitor, source_upper_monitor, source_pull_together;
  logic positive_buffer_bypass, negative_buffer_bypass, internal_source_on;
  logic filter_reset, converting, mod_tick;
  logic [7:0] addr, wr_data, rd_data;
  logic [3:0] rate_code;
  arvc_pkg::arvc_mon_t source_monitor_enable;
  arvc_pkg::arvc_sel_t source_select;
  int err_total = 0;
  int checks = 0;
  logic [7:0] rate_vals [6] = '{8'h80, 8'h40, 8'h20, 8'h00, 8'h0E, 8'h14};
  logic [7:0] src_vals [4] = '{8'h10, 8'h65, 8'hBA, 8'hC1};
  logic [2:0] mon_exp [4] = '{3'b000, 3'b100, 3'b110, 3'b101};
  logic [1:0] on_exp [4] = '{2'b00, 2'b10, 2'b11, 2'b10};
  always #5 ref_clk = ~ref_clk;
  always #37 ext_clk = ~ext_clk;
  arvc_rate_src i_arvc_rate_src (.ref_clk, .srst, .ext_clk, .wr_en, .rd_en, .addr, .wr_data,
    .rd_data, .rd_valid, .start_req, .power_down, .swap_average, .swap_phase, .ext_clk_select,
    .single_shot, .low_latency, .rate_code, .source_monitor_enable, .source_low_monitor,
    .source_upper_monitor, .source_pull_together, .positive_buffer_bypass,
    .negative_buffer_bypass, .source_select, .internal_source_on, .filter_reset, .converting,
    .mod_tick);
  arvc_host_model i_arvc_host_model (.ref_clk, .wr_en, .rd_en, .addr, .wr_data, .rd_data,
    .rd_valid);
  // ==========================================
  // Tasks
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    i_arvc_host_model.read_reg(a, d, ok);
    chk("read valid", 8'h01, {7'h00, ok});
    chk("read data", e, d);
  endtask : rd_chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_arvc_host_model.write_reg(a, d);
    #1;
  endtask : wr
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  // ==========================================
  // Tests
  initial begin
    logic r;
    logic sp;
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    rd_chk(8'h04, 8'h14);
    rd_chk(8'h05, 8'h10);
    chk("rate pins", 8'h14, {swap_average, ext_clk_select, single_shot, low_latency, rate_code});
    chk("src pins", 8'h10, {source_monitor_enable, positive_buffer_bypass,
      negative_buffer_bypass, source_select, 2'b00});
    $display("test reset values done");
    foreach (rate_vals[i]) begin
      wr(8'h04, rate_vals[i]);
      chk("filter reset", 8'h01, {7'h00, filter_reset});
      chk("rate pins", rate_vals[i], {swap_average, ext_clk_select, single_shot, low_latency,
        rate_code});
      rd_chk(8'h04, rate_vals[i]);
    end
    $display("test rate fields done");
    // Internal source sampled before power-down is raised and again during it, for each source register value
    foreach (src_vals[i]) begin
      wr(8'h05, src_vals[i]);
      r = internal_source_on;
      chk("src pins", {src_vals[i][7:2], 2'b00}, {source_monitor_enable, positive_buffer_bypass,
        negative_buffer_bypass, source_select, 2'b00});
      chk("monitors", {5'h00, mon_exp[i]}, {5'h00, source_low_monitor, source_upper_monitor,
        source_pull_together});
      @(posedge ref_clk);
      power_down <= 1'b1;
      @(posedge ref_clk);
      #1;
      chk("source on", {6'h00, on_exp[i]}, {6'h00, r, internal_source_on});
      @(posedge ref_clk);
      power_down <= 1'b0;
      rd_chk(8'h05, src_vals[i]);
    end
    $display("test source fields done");
    wr(8'h04, 8'h94);
    chk("converting", 8'h00, {7'h00, converting});
    repeat (1000) if (converting !== 1'b1) begin @(posedge ref_clk); #1; end
    chk("converting", 8'h01, {7'h00, converting});
    repeat (100) if (mod_tick !== 1'b1) begin @(posedge ref_clk); #1; end
    sp = swap_phase;
    @(posedge ref_clk);
    #1;
    chk("swap phase", {7'h00, ~sp}, {7'h00, swap_phase});
    wr(8'h04, 8'h94);
    chk("filter reset", 8'h00, {7'h00, filter_reset});
    chk("converting", 8'h01, {7'h00, converting});
    @(posedge ref_clk);
    start_req <= 1'b1;
    @(posedge ref_clk);
    start_req <= 1'b0;
    #1;
    chk("converting", 8'h00, {7'h00, converting});
    $display("test conversion restart done");
    wr(8'h06, 8'h55);
    rd_chk(8'h06, 8'h00);
    rd_chk(8'h04, 8'h94);
    rd_chk(8'h05, 8'hC1);
    $display("test unmapped access done");
    // Mid-run reset must bring both registers back before the next access
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rd_chk(8'h04, 8'h14);
    rd_chk(8'h05, 8'h10);
    chk("filter reset", 8'h00, {7'h00, filter_reset});
    chk("converting", 8'h00, {7'h00, converting});
    $display("test mid-run reset done");
    final_report();
  end
  // Far longer than the tests take, so only a hang reaches it
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    final_report();
  end
endmodule : adc_rate_and_vref_config_test
